//--- logic/tct_channel.v
`timescale 1ns/1ns
`default_nettype none
`include "tct_defs.vh"
module tct_channel (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Configuration strobes from the port decoder
    input wire mode_we,
    input wire [7:0] mode_data,
    input wire setup_we,
    input wire [7:0] setup_data,
    input wire load_we,
    input wire [7:0] load_data,
    // Reference ticks and hardware gate
    input wire fast_tick,
    input wire med_tick,
    input wire slow_tick,
    input wire hw_gate,
    // Channel state
    output reg chan_out,
    output reg tc_pulse,
    output reg [15:0] count,
    output reg running
);
    reg [2:0] mode_reg;
    reg bcd_reg;
    reg [1:0] rl_reg;
    reg [1:0] range_reg;
    reg gate_reg;
    reg [7:0] low_reg;
    reg high_phase_reg;
    reg tick;
    reg [15:0] dec_next;
    reg [15:0] tc_value;

    // Decrement one step, BCD digit wise when asked
    function [15:0] tct_dec;
        input [15:0] v;
        input bcd;
        integer i;
        reg borrow;
        begin
            tct_dec = v;
            borrow = 1'b1;
            if (!bcd) begin
                tct_dec = v - 16'h0001;
            end else begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (borrow) begin
                        if (v[i*4 +: 4] == 4'h0) begin
                            tct_dec[i*4 +: 4] = 4'h9; // 0000 wraps to 9999
                        end else begin
                            tct_dec[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                            borrow = 1'b0;
                        end
                    end
                end
            end
        end
    endfunction

    // Range selection and terminal count per mode
    always @* begin
        case (range_reg)
            `TCT_RANGE_FAST: tick = fast_tick;
            `TCT_RANGE_MED: tick = med_tick;
            default: tick = slow_tick; // Only long range passes 549 ms
        endcase
        case (mode_reg)
            3'h2: tc_value = 16'h0001;
            3'h3: tc_value = 16'h0002;
            default: tc_value = 16'h0000;
        endcase
        dec_next = tct_dec(count, bcd_reg); // Same delay either format
    end

    // Configuration, two byte load and counting
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= 3'h0;
            bcd_reg <= 1'b0;
            rl_reg <= `TCT_RL_BOTH;
            range_reg <= `TCT_RANGE_FAST;
            gate_reg <= 1'b0;
            low_reg <= 8'h00;
            high_phase_reg <= 1'b0;
            count <= 16'h0000;
            running <= 1'b0;
            chan_out <= 1'b0;
            tc_pulse <= 1'b0;
        end else begin
            tc_pulse <= 1'b0;
            if (mode_we) begin
                mode_reg <= mode_data[`TCT_MW_MODE_HI:`TCT_MW_MODE_LO];
                bcd_reg <= mode_data[`TCT_MW_BCD];
                rl_reg <= mode_data[`TCT_MW_RL_HI:`TCT_MW_RL_LO];
                high_phase_reg <= 1'b0;
                running <= 1'b0; // Hold until load completes
                if (mode_data[`TCT_MW_MODE_HI:`TCT_MW_MODE_LO] == 3'h0) begin
                    chan_out <= 1'b1; // Active at once
                end
            end else if (load_we) begin
                if (rl_reg == `TCT_RL_BOTH && !high_phase_reg) begin
                    low_reg <= load_data; // Bits 0-7 first
                    high_phase_reg <= 1'b1; // Wait for second byte
                end else begin
                    if (rl_reg == `TCT_RL_BOTH) begin
                        count <= {load_data, low_reg}; // Bits 8-15 second
                    end else if (rl_reg == 2'h2) begin
                        count <= {load_data, 8'h00};
                    end else begin
                        count <= {8'h00, load_data};
                    end
                    high_phase_reg <= 1'b0;
                    running <= 1'b1; // Delay starts on final byte
                end
            end else if (running && tick && gate_reg && hw_gate) begin
                count <= dec_next; // Gated by both gates
                if (dec_next == tc_value) begin
                    tc_pulse <= 1'b1;
                    if (mode_reg == 3'h0) begin
                        chan_out <= 1'b0; // Leaves active level at TC
                    end
                end
            end
            if (setup_we) begin
                range_reg <= setup_data[`TCT_SU_RANGE_HI:`TCT_SU_RANGE_LO];
                gate_reg <= setup_data[`TCT_SU_GATE];
            end
        end
    end
endmodule // tct_channel
`default_nettype wire

//--- logic/tct_defs.vh
`ifndef TCT_DEFS_VH
`define TCT_DEFS_VH
// Port addresses for channel 1 and shared ports
`define TCT_ADDR_LOAD1 8'hD9
`define TCT_ADDR_MODE 8'hDB
`define TCT_ADDR_SETUP1 8'hDD
`define TCT_ADDR_STATUS 8'hDF
// Mode word fields
`define TCT_MW_SEL_HI 7
`define TCT_MW_SEL_LO 6
`define TCT_MW_RL_HI 5
`define TCT_MW_RL_LO 4
`define TCT_MW_MODE_HI 3
`define TCT_MW_MODE_LO 1
`define TCT_MW_BCD 0
// Setup byte fields
`define TCT_SU_RANGE_HI 1
`define TCT_SU_RANGE_LO 0
`define TCT_SU_GATE 2
// Clock ranges
`define TCT_RANGE_FAST 2'h0
`define TCT_RANGE_MED 2'h1
`define TCT_RANGE_SLOW 2'h2
// Reference clock periods in ns
`define TCT_FAST_NS 500
`define TCT_MED_NS 8000
`define TCT_SLOW_NS 128000
`define TCT_MCLK_NS 10
`define TCT_FAST_CYC (`TCT_FAST_NS / `TCT_MCLK_NS)
`define TCT_MED_DIV (`TCT_MED_NS / `TCT_FAST_NS)
`define TCT_SLOW_DIV (`TCT_SLOW_NS / `TCT_MED_NS)
// Read/load field value for two byte loading
`define TCT_RL_BOTH 2'h3
`endif

//--- logic/tct_prescaler.v
`timescale 1ns/1ns
`default_nettype none
`include "tct_defs.vh"
module tct_prescaler #(
    parameter FAST_CYC = `TCT_FAST_CYC,
    parameter MED_DIV = `TCT_MED_DIV,
    parameter SLOW_DIV = `TCT_SLOW_DIV
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Range enables, one cycle each
    output reg fast_tick,
    output reg med_tick,
    output reg slow_tick
);
    reg [15:0] fast_cnt_reg;
    reg [7:0] med_cnt_reg;
    reg [7:0] slow_cnt_reg;
    // Cascaded dividers keep the three ranges phase related
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fast_cnt_reg <= 16'h0000;
            med_cnt_reg <= 8'h00;
            slow_cnt_reg <= 8'h00;
            fast_tick <= 1'b0;
            med_tick <= 1'b0;
            slow_tick <= 1'b0;
        end else begin
            fast_tick <= 1'b0;
            med_tick <= 1'b0;
            slow_tick <= 1'b0;
            if (fast_cnt_reg == FAST_CYC - 1) begin
                fast_cnt_reg <= 16'h0000;
                fast_tick <= 1'b1; // 0.5 us period
                if (med_cnt_reg == MED_DIV - 1) begin
                    med_cnt_reg <= 8'h00;
                    med_tick <= 1'b1; // 8 us period
                    if (slow_cnt_reg == SLOW_DIV - 1) begin
                        slow_cnt_reg <= 8'h00;
                        slow_tick <= 1'b1; // 128 us period
                    end else begin
                        slow_cnt_reg <= slow_cnt_reg + 8'h01;
                    end
                end else begin
                    med_cnt_reg <= med_cnt_reg + 8'h01;
                end
            end else begin
                fast_cnt_reg <= fast_cnt_reg + 16'h0001;
            end
        end
    end
endmodule // tct_prescaler
`default_nettype wire

//--- logic/tct_top.v
// Behaviour
// - Mode 0 write drives output active immediately
// - No counting until load register written
// - 16-bit binary count, four BCD digits
// - Binary or BCD, same delay
// - Fast range period is 0.5 us
// - Beyond 549 ms needs slow range
// - Unconnected hardware gate reads as one
// - Channel terminal count sets its interrupt latch
// - Latches readable at status port
// - Status write clears only bits set
// - Preload low byte then high byte
// - Delay starts at second byte write
// - Mode, setup, load ports separately decoded
// - Mode word 70 hex is channel 1 mode 0
// - Read/load 11 waits for both bytes
// - Terminal count depends on mode
// - Medium 8 us, slow 128 us periods
// - Software gate bit starts and stops count
`timescale 1ns/1ns
`default_nettype none
`include "tct_defs.vh"
module tct_top #(
    parameter NCHAN = 3
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Host I/O port access
    input wire [7:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    // Hardware gates, default high when unconnected
    input wire [NCHAN-1:0] hw_gate,
    input wire [1:0] spare_in,
    // Channel outputs and interrupt request
    output wire [NCHAN-1:0] chan_out,
    output wire int_req
);
    reg [NCHAN-1:0] latch_reg;
    reg [NCHAN-1:0] latch_next;
    wire fast_tick;
    wire med_tick;
    wire slow_tick;
    wire [NCHAN-1:0] tc_pulse;
    wire mode_hit;
    wire status_wr;
    wire [1:0] mode_sel;

    ////////////////////////////////////////////////////////////////////////
    // Port decode: mode port is shared, setup and load ports step by two
    function [1:0] port_chan;
        input [7:0] a;
        input [7:0] base;
        reg [7:0] diff;
        begin
            diff = a - base;
            port_chan = diff[2:1]; // Ports step by two, so drop bit 0
        end
    endfunction

    assign mode_hit = io_wr && (io_addr == `TCT_ADDR_MODE);
    assign mode_sel = io_wdata[`TCT_MW_SEL_HI:`TCT_MW_SEL_LO]; // 70 hex picks ch 1
    assign status_wr = io_wr && (io_addr == `TCT_ADDR_STATUS);

    tct_prescaler u_pre (
        .mclk(mclk),
        .rstn(rstn),
        .fast_tick(fast_tick),
        .med_tick(med_tick),
        .slow_tick(slow_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Channels; load ports at D7 (ch 0) and D9 (ch 1), setup port at DD for ch 1 only
    genvar g;
    generate
        for (g = 0; g < NCHAN; g = g + 1) begin : g_ch
            wire setup_we;
            wire load_we;
            // Channel 1 sits at the documented ports
            assign setup_we = io_wr && (io_addr[0] == 1'b1)
                && (port_chan(io_addr, `TCT_ADDR_SETUP1 - 8'h02) == g)
                && (io_addr >= `TCT_ADDR_SETUP1 - 8'h02)
                && (io_addr <= `TCT_ADDR_SETUP1 + 8'h00)
                && (io_addr != `TCT_ADDR_MODE);
            assign load_we = io_wr
                && (port_chan(io_addr, `TCT_ADDR_LOAD1 - 8'h02) == g)
                && (io_addr >= `TCT_ADDR_LOAD1 - 8'h02)
                && (io_addr <= `TCT_ADDR_LOAD1 + 8'h00)
                && (io_addr[0] == 1'b1);
            tct_channel u_ch (
                .mclk(mclk),
                .rstn(rstn),
                .mode_we(mode_hit && (mode_sel == g)),
                .mode_data(io_wdata),
                .setup_we(setup_we),
                .setup_data(io_wdata),
                .load_we(load_we),
                .load_data(io_wdata),
                .fast_tick(fast_tick),
                .med_tick(med_tick),
                .slow_tick(slow_tick),
                .hw_gate(hw_gate[g]), // Pull-up lives at the pin
                .chan_out(chan_out[g]),
                .tc_pulse(tc_pulse[g]),
                .count(),
                .running()
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupt latches: set on terminal count, write one to clear
    always @* begin
        latch_next = latch_reg;
        if (status_wr) begin
            latch_next = latch_reg & ~io_wdata[NCHAN-1:0];
        end
        latch_next = latch_next | tc_pulse; // Set wins over clear
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            latch_reg <= {NCHAN{1'b0}};
        end else begin
            latch_reg <= latch_next;
        end
    end

    assign int_req = |latch_reg;

    ////////////////////////////////////////////////////////////////////////
    // Status read: latches low, spare inputs in bits 6 and 7
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            io_rdata <= 8'h00;
        end else if (io_rd && io_addr == `TCT_ADDR_STATUS) begin
            io_rdata <= {spare_in, 3'h0, latch_reg};
        end else begin
            io_rdata <= 8'h00;
        end
    end
endmodule // tct_top
`default_nettype wire

//--- testbench/tct_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module tct_top_sva #(
    parameter NCHAN = 3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Host port
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // Card pins
    input wire logic [NCHAN-1:0] hw_gate,
    input wire logic [1:0] spare_in,
    input wire logic [NCHAN-1:0] chan_out,
    input wire logic int_req
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    logic mw1, st_we;
    logic [1:0] ld_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // Strobes of interest
    assign mw1 = io_wr && io_addr == 8'hDB && io_wdata[7:6] == 2'h1;
    assign st_we = io_wr && io_addr == 8'hDF;
    // Loads since channel 1 was set up; saturates so a wrapped count stays legal
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            ld_reg <= 2'h0;
        else if (mw1)
            ld_reg <= (io_wdata[5:4] == 2'h3) ? 2'h0 : 2'h2;
        else if (io_wr && io_addr == 8'hD9 && ld_reg != 2'h2)
            ld_reg <= ld_reg + 2'h1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_mode0_out;
        io_wr && io_addr == 8'hDB && io_wdata == 8'h70 |=> chan_out[1];
    endproperty
    a_mode0_out: assert property (p_mode0_out) else $error("mode 0 did not raise output");
    property p_load_order;
        $fell(chan_out[1]) && !$past(mw1) |-> ld_reg == 2'h2;
    endproperty
    a_load_order: assert property (p_load_order) else $error("count ended before both bytes");
    property p_tc_latch;
        $fell(chan_out[1]) && !$past(mw1) |-> ##[0:3] int_req;
    endproperty
    a_tc_latch: assert property (p_tc_latch) else $error("terminal count set no latch");
    property p_rd_status;
        io_rd && io_addr == 8'hDF |=> io_rdata[7:6] == $past(spare_in);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status spare bits wrong");
    property p_rd_idle;
        !(io_rd && io_addr == 8'hDF) |=> io_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without status read");
    property p_int_hold;
        int_req && !st_we && !$past(st_we) |=> int_req;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("request dropped uncleared");
    property p_clear_all;
        st_we && io_wdata[2:0] == 3'h7 ##1 ($stable(chan_out))[*2] |-> !int_req;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("latches not cleared");
    property p_unmapped_wr;
        io_wr && io_addr[7:4] != 4'hD |=> $stable(chan_out);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("stray write acted");
    // Main scenarios reached
    c_tc: cover property ($fell(chan_out[1]));
    c_rd_pending: cover property (io_rd && io_addr == 8'hDF && int_req);
    c_clear: cover property (st_we && int_req);
endmodule // tct_top_sva
bind tct_top tct_top_sva #(.NCHAN(NCHAN)) i_sva (.mclk(mclk), .rstn(rstn), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .hw_gate(hw_gate), .spare_in(spare_in), .chan_out(chan_out), .int_req(int_req));
`default_nettype wire

//--- testbench/tct_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module tct_host_model (
    // Clock
    input wire logic mclk,
    // Port bus towards the card
    output var logic [7:0] io_addr,
    output var logic io_wr,
    output var logic io_rd,
    output var logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    // Bus idles with no strobe
    initial begin
        io_addr = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // Write taken at the rising edge; released lines show the inverse, never stale data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge mclk);
        io_wr = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask
    // Read data is registered at the taking edge and stands one cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge mclk);
        d = io_rdata;
        io_rd = 1'b0;
        io_addr = ~a;
    endtask
    // Mode, control, own latch clear, low byte; one-shots only, so no baud mode
    task automatic arm(input logic [7:0] mw, input logic [7:0] su, input logic [7:0] lo);
        wr(8'hDB, mw);
        wr(8'hDD, su);
        wr(8'hDF, 8'h02);
        wr(8'hD9, lo);
    endtask
endmodule // tct_host_model
`default_nettype wire

//--- testbench/tct_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tct_top_tb;
    // Reference periods in mclk cycles: 0.5 us, 8 us, 128 us
    localparam int FAST_P = 50;
    localparam int MED_P = 800;
    localparam int SLOW_P = 12800;
    logic mclk, rstn, io_wr, io_rd, int_req;
    logic [7:0] io_addr, io_wdata, io_rdata, rd_val;
    logic [7:0] adr [3] = '{8'h55, 8'hD9, 8'hDB};
    logic [2:0] hw_gate, chan_out, exp_lat;
    logic [1:0] spare_in;
    logic [31:0] seed, r;
    int err_count, tests_run, c;
    ////////////////////////////////////////////////////////////////////////////////
    // Card clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Card and host
    tct_top #(.NCHAN(3)) i_dut (.mclk(mclk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .hw_gate(hw_gate),
        .spare_in(spare_in), .chan_out(chan_out), .int_req(int_req));
    tct_host_model i_host (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Status port against the latch model and the spare lines
    task automatic status_chk;
        i_host.rd(8'hDF, rd_val);
        check({rd_val[7:6], 3'h0, rd_val[2:0]}, {spare_in, 3'h0, exp_lat});
        check({7'h00, int_req}, {7'h00, |exp_lat});
    endtask
    // Bounded wait for channel 1 output to drop
    task automatic wait_fall(input int lim);
        c = 0;
        while (chan_out[1] === 1'b1 && c < lim) begin
            @(negedge mclk);
            c++;
        end
    endtask
    // Mode 0 delay; a tick may land anywhere in the first period, hence the window
    task automatic delay_run(input logic [7:0] mw, su, lo, hi, input int ticks, per);
        exp_lat[1] = 1'b0;
        r = $random(seed);
        spare_in = r[1:0];
        i_host.arm(mw, su, lo);
        repeat (per + 10) @(negedge mclk);
        check({7'h00, chan_out[1]}, 8'h01);
        i_host.wr(8'hD9, hi);
        wait_fall(ticks * per + 100);
        check({7'h00, c >= (ticks - 1) * per && c <= ticks * per + 4}, 8'h01);
        exp_lat[1] = 1'b1;
        status_chk();
        $display("delay of %0d ticks done", ticks);
    endtask
    // Single byte loads in modes 2 and 3; only the latch marks terminal count there
    task automatic tc_run(input logic [7:0] mw, dat, input int ticks);
        exp_lat[1] = 1'b0;
        i_host.wr(8'hDB, mw);
        i_host.wr(8'hDD, 8'h04);
        i_host.wr(8'hDF, 8'h02);
        status_chk();
        i_host.wr(8'hD9, dat);
        c = 0;
        while (int_req !== 1'b1 && c < ticks * FAST_P + 100) begin
            @(negedge mclk);
            c++;
        end
        check({7'h00, c >= (ticks - 1) * FAST_P && c <= ticks * FAST_P + 4}, 8'h01);
        exp_lat[1] = 1'b1;
        status_chk();
        $display("terminal count in mode %0d done", mw[3:1]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 32'hBE92F977;
        rstn = 1'b0;
        hw_gate = 3'h7;
        spare_in = 2'h0;
        exp_lat = 3'h0;
        err_count = 0;
        tests_run = 0;
        repeat (20) @(negedge mclk);
        check({5'h00, chan_out}, 8'h00);
        rstn = 1'b1;
        status_chk();
        for (int ch = 0; ch < 3; ch++) begin
            i_host.wr(8'hDB, {ch[1:0], 6'h30});
            check({7'h00, chan_out[ch]}, 8'h01);
        end
        i_host.wr(8'h55, 8'hFF);
        check({5'h00, chan_out}, 8'h07);
        for (int i = 0; i < 3; i++) begin
            i_host.rd(adr[i], rd_val);
            check(rd_val, 8'h00);
        end
        $display("reset and decode test done");
        r = $random(seed);
        delay_run(8'h70, 8'h04, {5'h00, r[2:0]} + 8'h02, 8'h00, r[2:0] + 2, FAST_P);
        delay_run(8'h71, 8'h04, 8'h00, 8'h01, 100, FAST_P);
        delay_run(8'h70, 8'h04, 8'h64, 8'h00, 100, FAST_P);
        delay_run(8'h70, 8'h05, 8'h02, 8'h00, 2, MED_P);
        delay_run(8'h70, 8'h06, 8'h01, 8'h00, 1, SLOW_P);
        // Either gate off holds the count; both on let it run out
        hw_gate[1] = 1'b0;
        exp_lat[1] = 1'b0;
        i_host.arm(8'h70, 8'h00, 8'h02);
        i_host.wr(8'hD9, 8'h00);
        i_host.wr(8'hDD, 8'h04);
        repeat (200) @(negedge mclk);
        check({7'h00, chan_out[1]}, 8'h01);
        i_host.wr(8'hDD, 8'h00);
        hw_gate[1] = 1'b1;
        repeat (200) @(negedge mclk);
        check({7'h00, chan_out[1]}, 8'h01);
        i_host.wr(8'hDD, 8'h04);
        wait_fall(300);
        check({7'h00, c <= 2 * FAST_P + 4}, 8'h01);
        exp_lat[1] = 1'b1;
        $display("gate test done");
        tc_run(8'h54, 8'h03, 2);
        tc_run(8'h66, 8'h01, 254);
        // Other bits leave channel 1 pending; an all-ones write clears it
        i_host.wr(8'hDF, 8'h05);
        status_chk();
        i_host.wr(8'hDF, 8'h07);
        exp_lat[1] = 1'b0;
        status_chk();
        $display("latch test done");
        complete_run();
    end
    // Watchdog well beyond the longest expected run
    initial begin
        repeat (90000) @(posedge mclk);
        err_count++;
        complete_run();
    end
endmodule // tct_top_tb
`default_nettype wire
